// file: shared/ride_pkg.sv
// constants and types shared by the instruction decode and execute core
package ride_pkg;
	// ***********************
	// instruction word layout
	// ***********************
	localparam int INSTR_W = 14;
	localparam int DATA_W = 8;
	localparam int FADDR_W = 7;
	localparam int PC_W = 11;
	localparam int STACK_DEPTH = 8;
	localparam int GRP_HI = 13;
	localparam int GRP_LO = 12;
	localparam int OP_HI = 11;
	localparam int OP_LO = 8;
	localparam int DEST_BIT = 7;
	localparam int BSEL_HI = 9;
	localparam int BSEL_LO = 7;
	localparam logic [1:0] GRP_BYTE = 2'h0;
	localparam logic [1:0] GRP_BIT = 2'h1;
	localparam logic [1:0] GRP_JUMP = 2'h2;
	localparam logic [1:0] GRP_LIT = 2'h3;
	localparam logic [INSTR_W-1:0] INSTR_NOP = 14'h0000;
	localparam logic [6:0] MISC_RETURN = 7'h08;
	localparam logic [6:0] MISC_RETFIE = 7'h09;
	localparam logic [6:0] MISC_SLEEP = 7'h63;
	localparam logic [6:0] MISC_CLRWDT = 7'h64;

	// ***********************
	// file space and timing
	// ***********************
	localparam logic [FADDR_W-1:0] GPIO_PORT_ADDR = 7'h05;
	localparam logic [FADDR_W-1:0] TIMER_ZERO_ADDR = 7'h01;
	localparam int CLKS_PER_INSTR = 4;

	// ***********************
	// register bus map
	// ***********************
	localparam int APB_AW = 12;
	localparam logic [APB_AW-1:0] CTRL_OFS = 12'h000;
	localparam logic [APB_AW-1:0] STAT_OFS = 12'h004;
	localparam logic [APB_AW-1:0] PC_OFS = 12'h008;
	localparam int CTRL_RUN_BIT = 0;
	localparam int STAT_C_BIT = 8;
	localparam int STAT_DC_BIT = 9;
	localparam int STAT_Z_BIT = 10;
	localparam int STAT_TO_BIT = 11;
	localparam int STAT_PD_BIT = 12;
	localparam logic CTRL_RUN_RST = 1'b0;
	localparam logic FLAG_TO_RST = 1'b1;
	localparam logic FLAG_PD_RST = 1'b1;

	typedef enum logic [3:0] {
		PH_Q1 = 4'b0001,
		PH_Q2 = 4'b0010,
		PH_Q3 = 4'b0100,
		PH_Q4 = 4'b1000
	} ride_phase_e;
endpackage

// file: design/ride_alu.sv
// combinational data path for byte, bit and literal operations
module ride_alu
	import ride_pkg::*;
(
	input wire logic [ride_pkg::INSTR_W-1:0] instr,
	input wire logic [ride_pkg::DATA_W-1:0] w_val,
	input wire logic [ride_pkg::DATA_W-1:0] f_val,
	input wire logic c_in,
	output logic [ride_pkg::DATA_W-1:0] res,
	output logic c_out,
	output logic dc_out,
	output logic upd_c,
	output logic upd_dc,
	output logic upd_z
);
	import ride_pkg::*;

	logic [DATA_W:0] sum;
	logic [4:0] nib;
	logic [DATA_W-1:0] lit;
	logic [DATA_W-1:0] bmask;

	assign lit = instr[DATA_W-1:0];
	assign bmask = 8'h01 << instr[BSEL_HI:BSEL_LO];

	// ***********************
	// operation select
	// ***********************
	always_comb
	begin
		sum = '0;
		nib = '0;
		res = f_val;
		c_out = c_in;
		dc_out = 1'b0;
		upd_c = 1'b0;
		upd_dc = 1'b0;
		upd_z = 1'b0;
		unique casez (instr[GRP_HI:OP_LO])
			6'b00_0111: begin sum = {1'b0, f_val} + {1'b0, w_val}; nib = {1'b0, f_val[3:0]} + {1'b0, w_val[3:0]}; end
			6'b00_0010: begin sum = {1'b0, f_val} + {1'b0, ~w_val} + 9'h001; nib = {1'b0, f_val[3:0]} + {1'b0, ~w_val[3:0]} + 5'h01; end
			6'b11_111?: begin sum = {1'b0, lit} + {1'b0, w_val}; nib = {1'b0, lit[3:0]} + {1'b0, w_val[3:0]}; end
			6'b11_110?: begin sum = {1'b0, lit} + {1'b0, ~w_val} + 9'h001; nib = {1'b0, lit[3:0]} + {1'b0, ~w_val[3:0]} + 5'h01; end
			default: sum = '0;
		endcase
		unique casez (instr[GRP_HI:OP_LO])
			6'b00_0111, 6'b00_0010, 6'b11_111?, 6'b11_110?:
			begin
				res = sum[DATA_W-1:0];
				c_out = sum[DATA_W];
				dc_out = nib[4];
				upd_c = 1'b1;
				upd_dc = 1'b1;
				upd_z = 1'b1;
			end
			6'b00_0101: begin res = w_val & f_val; upd_z = 1'b1; end
			6'b00_0001: begin res = 8'h00; upd_z = 1'b1; end
			6'b00_1001: begin res = ~f_val; upd_z = 1'b1; end
			6'b00_0011: begin res = f_val - 8'h01; upd_z = 1'b1; end
			6'b00_1011: res = f_val - 8'h01;
			6'b00_1010: begin res = f_val + 8'h01; upd_z = 1'b1; end
			6'b00_1111: res = f_val + 8'h01;
			6'b00_0100: begin res = w_val | f_val; upd_z = 1'b1; end
			6'b00_1000: upd_z = 1'b1;
			6'b00_0000: res = w_val;
			6'b00_1101: begin res = {f_val[6:0], c_in}; c_out = f_val[7]; upd_c = 1'b1; end
			6'b00_1100: begin res = {c_in, f_val[7:1]}; c_out = f_val[0]; upd_c = 1'b1; end
			6'b00_1110: res = {f_val[3:0], f_val[7:4]};
			6'b00_0110: begin res = w_val ^ f_val; upd_z = 1'b1; end
			6'b01_00??: res = f_val & ~bmask;
			6'b01_01??: res = f_val | bmask;
			6'b01_1???: res = f_val;
			6'b10_????: res = w_val;
			6'b11_00??, 6'b11_01??: res = lit;
			6'b11_1000: begin res = w_val | lit; upd_z = 1'b1; end
			6'b11_1001: begin res = w_val & lit; upd_z = 1'b1; end
			6'b11_1010: begin res = w_val ^ lit; upd_z = 1'b1; end
			default: res = f_val;
		endcase
	end
endmodule

// file: design/ride_core.sv
// instruction decode and execute core with four-phase cycle and apb control
// What this block does
// - every instruction is one 14-bit word, opcode plus operand fields
// - decode into byte-file, bit-file and literal-control groups
// - byte op result goes to working register if d is 0, else file
// - file address operand selects one of registers 0x00 to 0x7F
// - bit select picks one bit of the 8-bit file register
// - literal operand is 8 bits for data, 11 bits for jump targets
// - one instruction cycle lasts four clock periods
// - taken skips and program counter changes take two cycles, second a nop
// - any file-naming instruction reads the register before storing
// - writing the port register also reads it, clearing pin-change mismatch
// - don't care opcode bits give the same result either way
// - one working register is the implicit accumulator operand
// - port read-modify-write uses pin levels, not the output latch
// - writing timer zero count clears prescaler when assigned to it
module ride_core
	import ride_pkg::*;
#(
	parameter int DEPTH = ride_pkg::STACK_DEPTH
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ride_pkg::APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [ride_pkg::PC_W-1:0] pm_addr,
	input wire logic [ride_pkg::INSTR_W-1:0] pm_rdata,
	output logic [ride_pkg::FADDR_W-1:0] f_addr,
	output logic f_rd,
	input wire logic [ride_pkg::DATA_W-1:0] f_rdata,
	output logic f_wr,
	output logic [ride_pkg::DATA_W-1:0] f_wdata,
	input wire logic [ride_pkg::DATA_W-1:0] port_pins,
	input wire logic prescaler_on_timer_zero,
	output logic timer_zero_prescaler_clr
);
	import ride_pkg::*;

	localparam int SP_W = $clog2(DEPTH);

	// ***********************
	// decode helpers
	// ***********************
	function automatic logic names_file(input logic [INSTR_W-1:0] i);
		names_file = (i[GRP_HI:GRP_LO] == GRP_BIT) ||
			((i[GRP_HI:GRP_LO] == GRP_BYTE) && (i[DEST_BIT] || (i[OP_HI:OP_LO + 1] != 3'h0)));
	endfunction

	function automatic logic is_misc(input logic [INSTR_W-1:0] i, input logic [6:0] code);
		is_misc = (i[GRP_HI:DEST_BIT] == 7'h00) && (i[6:0] == code);
	endfunction

	ride_phase_e phase_r, phase_nxt;
	logic [INSTR_W-1:0] ir_r, ir_nxt;
	logic [PC_W-1:0] pc_r, pc_nxt;
	logic [PC_W-1:0] stack_r [DEPTH];
	logic [PC_W-1:0] stack_nxt [DEPTH];
	logic [SP_W-1:0] sp_r, sp_nxt;
	logic flush_r, flush_nxt, taken_r, taken_nxt;
	logic [DATA_W-1:0] w_r, w_nxt, fval_r, fval_nxt, f_wdata_r, f_wdata_nxt;
	logic c_r, c_nxt, dc_r, dc_nxt, z_r, z_nxt, to_r, to_nxt, pd_r, pd_nxt;
	logic [FADDR_W-1:0] f_addr_r, f_addr_nxt;
	logic f_rd_r, f_rd_nxt, f_wr_r, f_wr_nxt, t0clr_r, t0clr_nxt;
	logic run_r, run_nxt, pready_r, pready_nxt, pslverr_r, pslverr_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic [DATA_W-1:0] alu_res;
	logic alu_c, alu_dc, upd_c, upd_dc, upd_z;
	logic [1:0] grp;
	logic dest_f, wr_w, wr_f, skip, branch, ret;

	ride_alu u_alu
	(
		.instr(ir_r),
		.w_val(w_r),
		.f_val(fval_r),
		.c_in(c_r),
		.res(alu_res),
		.c_out(alu_c),
		.dc_out(alu_dc),
		.upd_c(upd_c),
		.upd_dc(upd_dc),
		.upd_z(upd_z)
	);

	// ***********************
	// instruction decode
	// ***********************
	always_comb
	begin
		grp = ir_r[GRP_HI:GRP_LO];
		dest_f = ir_r[DEST_BIT];
		wr_f = ((grp == GRP_BYTE) && dest_f) || ((grp == GRP_BIT) && !ir_r[OP_HI]);
		wr_w = ((grp == GRP_BYTE) && !dest_f && (ir_r[OP_HI:OP_LO] != 4'h0)) || (grp == GRP_LIT);
		skip = ((grp == GRP_BYTE) && (ir_r[OP_HI:OP_LO] == 4'hB || ir_r[OP_HI:OP_LO] == 4'hF)
			&& (alu_res == 8'h00))
			|| ((grp == GRP_BIT) && ir_r[OP_HI]
			&& (fval_r[ir_r[BSEL_HI:BSEL_LO]] == ir_r[OP_HI - 1]));
		ret = is_misc(ir_r, MISC_RETURN) || is_misc(ir_r, MISC_RETFIE)
			|| ((grp == GRP_LIT) && (ir_r[OP_HI:OP_HI - 1] == 2'h1));
		branch = (grp == GRP_JUMP) || ret;
	end

	// ***********************
	// four-phase execution
	// ***********************
	always_comb
	begin
		phase_nxt = phase_r;
		ir_nxt = ir_r;
		pc_nxt = pc_r;
		stack_nxt = stack_r;
		sp_nxt = sp_r;
		flush_nxt = flush_r;
		taken_nxt = taken_r;
		w_nxt = w_r;
		fval_nxt = fval_r;
		f_wdata_nxt = f_wdata_r;
		c_nxt = c_r;
		dc_nxt = dc_r;
		z_nxt = z_r;
		to_nxt = to_r;
		pd_nxt = pd_r;
		f_addr_nxt = f_addr_r;
		f_rd_nxt = 1'b0;
		f_wr_nxt = f_wr_r;
		t0clr_nxt = t0clr_r;
		unique case (phase_r)
			PH_Q1:
			begin
				phase_nxt = PH_Q2;
				fval_nxt = (f_addr_r == GPIO_PORT_ADDR) ? port_pins : f_rdata;
			end
			PH_Q2:
			begin
				phase_nxt = PH_Q3;
				taken_nxt = !flush_r && (skip || branch);
				if (!flush_r)
				begin
					if (wr_w)
						w_nxt = alu_res;
					if (upd_c)
						c_nxt = alu_c;
					if (upd_dc)
						dc_nxt = alu_dc;
					if (upd_z)
						z_nxt = (alu_res == 8'h00);
					if (is_misc(ir_r, MISC_CLRWDT))
					begin
						to_nxt = 1'b1;
						pd_nxt = 1'b1;
					end
					if (is_misc(ir_r, MISC_SLEEP))
					begin
						to_nxt = 1'b1;
						pd_nxt = 1'b0;
					end
					f_wr_nxt = wr_f;
					f_wdata_nxt = alu_res;
					t0clr_nxt = wr_f && (f_addr_r == TIMER_ZERO_ADDR) && prescaler_on_timer_zero;
				end
			end
			PH_Q3:
			begin
				phase_nxt = PH_Q4;
				f_wr_nxt = 1'b0;
				t0clr_nxt = 1'b0;
			end
			PH_Q4:
			begin
				// a halt only takes hold between instructions
				if (run_r)
				begin
					phase_nxt = PH_Q1;
					flush_nxt = taken_r;
					taken_nxt = 1'b0;
					if (taken_r && (grp == GRP_JUMP))
					begin
						pc_nxt = ir_r[PC_W-1:0];
						if (!ir_r[OP_HI])
						begin
							stack_nxt[sp_r] = pc_r;
							sp_nxt = sp_r + 1'b1;
						end
					end
					else if (taken_r && ret)
					begin
						pc_nxt = stack_r[sp_r - 1'b1];
						sp_nxt = sp_r - 1'b1;
					end
					else
					begin
						pc_nxt = pc_r + 1'b1;
						if (!taken_r)
							ir_nxt = pm_rdata;
					end
					f_addr_nxt = pm_rdata[FADDR_W-1:0];
					f_rd_nxt = !taken_r && names_file(pm_rdata);
				end
			end
			default: phase_nxt = PH_Q4;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			phase_r <= PH_Q4;
			ir_r <= INSTR_NOP;
			pc_r <= '0;
			for (int i = 0; i < DEPTH; i++)
				stack_r[i] <= '0;
			sp_r <= '0;
			flush_r <= 1'b0;
			taken_r <= 1'b0;
			w_r <= '0;
			fval_r <= '0;
			f_wdata_r <= '0;
			c_r <= 1'b0;
			dc_r <= 1'b0;
			z_r <= 1'b0;
			to_r <= FLAG_TO_RST;
			pd_r <= FLAG_PD_RST;
			f_addr_r <= '0;
			f_rd_r <= 1'b0;
			f_wr_r <= 1'b0;
			t0clr_r <= 1'b0;
		end
		else
		begin
			phase_r <= phase_nxt;
			ir_r <= ir_nxt;
			pc_r <= pc_nxt;
			stack_r <= stack_nxt;
			sp_r <= sp_nxt;
			flush_r <= flush_nxt;
			taken_r <= taken_nxt;
			w_r <= w_nxt;
			fval_r <= fval_nxt;
			f_wdata_r <= f_wdata_nxt;
			c_r <= c_nxt;
			dc_r <= dc_nxt;
			z_r <= z_nxt;
			to_r <= to_nxt;
			pd_r <= pd_nxt;
			f_addr_r <= f_addr_nxt;
			f_rd_r <= f_rd_nxt;
			f_wr_r <= f_wr_nxt;
			t0clr_r <= t0clr_nxt;
		end
	end

	// ***********************
	// apb slave
	// ***********************
	always_comb
	begin
		run_nxt = run_r;
		pready_nxt = 1'b0;
		pslverr_nxt = 1'b0;
		prdata_nxt = prdata_r;
		// answer in the first access cycle, so no wait states
		if (psel && !penable)
		begin
			pready_nxt = 1'b1;
			prdata_nxt = '0;
			unique case (paddr)
				CTRL_OFS: prdata_nxt[CTRL_RUN_BIT] = run_r;
				STAT_OFS:
				begin
					prdata_nxt[DATA_W-1:0] = w_r;
					prdata_nxt[STAT_C_BIT] = c_r;
					prdata_nxt[STAT_DC_BIT] = dc_r;
					prdata_nxt[STAT_Z_BIT] = z_r;
					prdata_nxt[STAT_TO_BIT] = to_r;
					prdata_nxt[STAT_PD_BIT] = pd_r;
				end
				PC_OFS: prdata_nxt[PC_W-1:0] = pc_r;
				default: pslverr_nxt = 1'b1;
			endcase
		end
		if (psel && penable && pready_r && pwrite && (paddr == CTRL_OFS))
			run_nxt = pwdata[CTRL_RUN_BIT];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			run_r <= CTRL_RUN_RST;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= '0;
		end
		else
		begin
			run_r <= run_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			prdata_r <= prdata_nxt;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign pm_addr = pc_r;
	assign f_addr = f_addr_r;
	assign f_rd = f_rd_r;
	assign f_wr = f_wr_r;
	assign f_wdata = f_wdata_r;
	assign timer_zero_prescaler_clr = t0clr_r;

	// ***********************
	// checks
	// ***********************
	a_phase_step: assert property (@(posedge pclk) disable iff (!presetn)
		(phase_r == PH_Q1) |=> (phase_r == PH_Q2) ##1 (phase_r == PH_Q3) ##1 (phase_r == PH_Q4))
		else $error("phase sequence broken");
	a_rmw_read: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(f_wr_r) |-> $past(f_rd_r, 2))
		else $error("file write without prior read");
	a_fetch_addr: assert property (@(posedge pclk) disable iff (!presetn)
		f_rd_r |-> (f_addr_r == ir_r[FADDR_W-1:0]) && (phase_r == PH_Q1))
		else $error("file address not from operand");
	a_dest_work: assert property (@(posedge pclk) disable iff (!presetn)
		(phase_r == PH_Q3 && !flush_r && grp == GRP_BYTE && !dest_f) |-> !f_wr_r)
		else $error("d=0 wrote file register");
	a_bit_set: assert property (@(posedge pclk) disable iff (!presetn)
		(phase_r == PH_Q3 && !flush_r && ir_r[GRP_HI:OP_HI - 1] == 4'h5)
		|-> f_wdata_r == (fval_r | (8'h01 << ir_r[BSEL_HI:BSEL_LO])))
		else $error("bit set wrong");
	a_pin_read: assert property (@(posedge pclk) disable iff (!presetn)
		(phase_r == PH_Q1 && f_addr_r == GPIO_PORT_ADDR) |=> fval_r == $past(port_pins))
		else $error("port read not from pins");
	a_skip_nop: assert property (@(posedge pclk) disable iff (!presetn)
		(phase_r == PH_Q4 && run_r && taken_r) |=> flush_r ##4 !flush_r)
		else $error("taken instruction without single nop");
	a_jump_tgt: assert property (@(posedge pclk) disable iff (!presetn)
		(phase_r == PH_Q4 && run_r && taken_r && grp == GRP_JUMP)
		|=> pc_r == $past(ir_r[PC_W-1:0]))
		else $error("jump target wrong");
	a_lit_move: assert property (@(posedge pclk) disable iff (!presetn)
		(phase_r == PH_Q2 && !flush_r && ir_r[GRP_HI:OP_HI - 1] == 4'hC) |=> w_r == $past(ir_r[7:0]))
		else $error("literal move to W wrong");
	a_t0_clear: assert property (@(posedge pclk) disable iff (!presetn)
		(f_wr_r && f_addr_r == TIMER_ZERO_ADDR && prescaler_on_timer_zero && phase_r == PH_Q3)
		|-> t0clr_r)
		else $error("prescaler not cleared");
endmodule

// file: sim/ride_mem_model.sv
// program memory and file register space seen by the core
module ride_mem_model
	import ride_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [ride_pkg::PC_W-1:0] pm_addr,
	output logic [ride_pkg::INSTR_W-1:0] pm_rdata,
	input wire logic [ride_pkg::FADDR_W-1:0] f_addr,
	input wire logic f_rd,
	output logic [ride_pkg::DATA_W-1:0] f_rdata,
	input wire logic f_wr,
	input wire logic [ride_pkg::DATA_W-1:0] f_wdata,
	input wire logic presc_clr
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [INSTR_W-1:0] prog [0:2047] = '{default: '0};
	logic [DATA_W-1:0] file [0:127] = '{default: '0};
	int cyc;
	int last;
	int gap;
	int rd_cnt;
	int port_rd;
	int clr_cnt;
	// *****************
	// read paths
	// *****************
	assign pm_rdata = prog[pm_addr];
	// garbage outside the read pulse, so a late sample is caught
	assign f_rdata = f_rd ? file[f_addr] : ~file[f_addr];
	// *****************
	// writes and event counts
	// *****************
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cyc <= 0;
			last <= 0;
			gap <= 0;
			rd_cnt <= 0;
			port_rd <= 0;
			clr_cnt <= 0;
		end
		else
		begin
			cyc <= cyc + 1;
			if (f_wr)
			begin
				file[f_addr] <= f_wdata;
				gap <= cyc - last;
				last <= cyc;
			end
			if (f_rd)
				rd_cnt <= rd_cnt + 1;
			if (f_rd && f_addr == GPIO_PORT_ADDR)
				port_rd <= port_rd + 1;
			if (presc_clr)
				clr_cnt <= clr_cnt + 1;
		end
	end
endmodule

// file: sim/ride_core_test.sv
// self-checking bench for the decode and execute core
module ride_core_test;
	import ride_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [APB_AW-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [PC_W-1:0] pm_addr;
	logic [INSTR_W-1:0] pm_rdata;
	logic [FADDR_W-1:0] f_addr;
	logic f_rd;
	logic [DATA_W-1:0] f_rdata;
	logic f_wr;
	logic [DATA_W-1:0] f_wdata;
	logic [DATA_W-1:0] port_pins = 8'h00;
	logic presc_on = 1'b0;
	logic presc_clr;
	int n_mismatch = 0;
	int compares = 0;
	int ticks = 0;
	logic [31:0] q;
	logic e;

	ride_core u_ride_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pm_addr(pm_addr), .pm_rdata(pm_rdata), .f_addr(f_addr),
		.f_rd(f_rd), .f_rdata(f_rdata), .f_wr(f_wr), .f_wdata(f_wdata),
		.port_pins(port_pins), .prescaler_on_timer_zero(presc_on),
		.timer_zero_prescaler_clr(presc_clr));
	ride_mem_model u_mem (.pclk(pclk), .presetn(presetn), .pm_addr(pm_addr),
		.pm_rdata(pm_rdata), .f_addr(f_addr), .f_rd(f_rd), .f_rdata(f_rdata), .f_wr(f_wr),
		.f_wdata(f_wdata), .presc_clr(presc_clr));

	always #5 pclk = ~pclk;

	// ceiling well above the few hundred cycles the scenarios need
	always @(posedge pclk)
	begin
		ticks <= ticks + 1;
		if (ticks == 20000)
		begin
			n_mismatch++;
			results();
		end
	end

	// *****************
	// shared tasks
	// *****************
	task automatic results();
		if (n_mismatch == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] s);
		compares++;
		if (s !== x)
		begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, x, s);
		end
	endtask

	// answer taken at the edge where pready is seen high, then released
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// values read here are those the slave saw at this edge
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// one idle edge, so a following call never reassigns psel in the same step
		@(posedge pclk);
	endtask

	// restart the core on a fresh program; the file space keeps its contents
	task automatic run(input logic [13:0] p [8]);
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		foreach (p[i])
			u_mem.prog[i] = p[i];
		@(posedge pclk);
		apb(1'b1, CTRL_OFS, 32'h1);
		repeat (60) @(posedge pclk);
	endtask

	// *****************
	// scenarios
	// *****************
	task automatic t_apb();
		apb(1'b0, CTRL_OFS, 32'h0);
		chk("ctrl", 32'h0, q);
		apb(1'b0, STAT_OFS, 32'h0);
		chk("flags", 32'h3, 32'(q[12:11]));
		apb(1'b0, 12'h00C, 32'h0);
		chk("err", 32'h1, 32'(e));
		chk("errdata", 32'h0, q);
	endtask

	task automatic t_byte();
		run('{14'h305A, 14'h00A0, 14'h0720, 14'h00A1, 14'h0AA0, 14'h33C3, 14'h00A3, 14'h0});
		chk("f20", 32'h5B, 32'(u_mem.file[32]));
		chk("f21", 32'hB4, 32'(u_mem.file[33]));
		chk("f23", 32'hC3, 32'(u_mem.file[35]));
		chk("reads", 32'd5, 32'(u_mem.rd_cnt));
		chk("gap", 32'd8, 32'(u_mem.gap));
		apb(1'b0, STAT_OFS, 32'h0);
		chk("w", 32'hC3, 32'(q[7:0]));
		chk("cdz", 32'h2, 32'(q[10:8]));
	endtask

	task automatic t_bit();
		u_mem.file[34] = 8'h01;
		u_mem.file[127] = 8'h00;
		run('{14'h17A2, 14'h1022, 14'h147F, 14'h0, 14'h0, 14'h0, 14'h0, 14'h0});
		chk("f22", 32'h80, 32'(u_mem.file[34]));
		chk("f7f", 32'h01, 32'(u_mem.file[127]));
	endtask

	task automatic t_port();
		u_mem.file[5] = 8'hFF;
		port_pins <= 8'h3C;
		presc_on <= 1'b1;
		run('{14'h0185, 14'h0885, 14'h0181, 14'h0, 14'h0, 14'h0, 14'h0, 14'h0});
		chk("port", 32'h3C, 32'(u_mem.file[5]));
		chk("portrd", 32'd2, 32'(u_mem.port_rd));
		chk("pclr", 32'd1, 32'(u_mem.clr_cnt));
		presc_on <= 1'b0;
	endtask

	task automatic t_flow();
		u_mem.file[48] = 8'h77;
		u_mem.file[49] = 8'h77;
		run('{14'h3011, 14'h00B3, 14'h2804, 14'h00B0, 14'h1822, 14'h00B1, 14'h00B4, 14'h0});
		chk("gap", 32'd20, 32'(u_mem.gap));
		chk("f30", 32'h77, 32'(u_mem.file[48]));
		chk("f31", 32'h77, 32'(u_mem.file[49]));
		chk("f34", 32'h11, 32'(u_mem.file[52]));
	endtask

	// call, literal return, sleep, then a jump to itself
	task automatic t_call();
		run('{14'h2004, 14'h00B5, 14'h0063, 14'h2803, 14'h3442, 14'h0, 14'h0, 14'h0});
		chk("f35", 32'h42, 32'(u_mem.file[53]));
		apb(1'b0, STAT_OFS, 32'h0);
		chk("wret", 32'h42, 32'(q[7:0]));
		chk("sleep", 32'h1, 32'(q[12:11]));
	endtask

	// *****************
	// main sequence
	// *****************
	initial
	begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_apb();
		t_byte();
		t_bit();
		t_port();
		t_flow();
		t_call();
		results();
	end
endmodule
